//--- hw/gfs_fault_supervisor.sv
// What this block does
// R01: strong pulldown while opposite gate turns on
// R02: timer expiry compares gate with command
// R03: two programmable timer settings, one per polarity
// R04: disable bit suppresses gate mismatch detection
// R05: source pin overcurrent latches shutdown, per phase
// R06: supply faults pull gates low, supplies off
// R07: drain-source overcurrent follows latched, report or disabled mode
// R08: main supply low warning toggles pin only
// R09: main supply high warning toggles pin only
// R10: driver lockout latches shutdown, status bit ten
// R11: lockout disable stops shutdown, keeps status
// R12: pump overvoltages latch faults, bits one, zero
// R13: pump undervoltage latches shutdown, bit two
// R14: lowside regulator undervoltage latches shutdown, bit four
// R15: gate supply undervoltage never disabled
// R16: five undervoltage, two overvoltage monitor inputs
// R17: faults clear on clear bit or enable pulse
// R18: warning pulses pin until status read
// R19: any fault holds pin, sets summary
// R20: temperature flags real time, never pin
// R21: monitors synchronised; fault beats warning on pin
`timescale 1ns/1ps
`default_nettype none
module gfs_fault_supervisor #(
	parameter int WARN_HALF_CYC = gfs_pkg::WARN_HALF_CYC,
	parameter int GATE_UNIT_CYC = gfs_pkg::GATE_UNIT_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// gate drive
	input wire logic gate_enable_i,
	input wire logic [5:0] gate_cmd_i,
	input wire logic [5:0] gate_fb_i,
	output logic [5:0] gate_out_o,
	output logic [5:0] strong_pd_o,
	output logic gate_supply_en_o,
	// supply, temperature and overcurrent monitors
	input wire logic [gfs_pkg::MON_W-1:0] monitor_i,
	// open-drain fault pin
	input wire logic fault_out_n_i,
	output logic fault_out_n_o,
	output logic fault_out_n_oe_o
);
	localparam int TOG_W = $clog2(WARN_HALF_CYC + 1);

	function automatic logic hit(input logic [5:0] idx, input logic [5:0] reg_idx);
		return idx == reg_idx;
	endfunction : hit

	// ****************************************************************
	// monitor synchroniser
	// ****************************************************************
	logic [gfs_pkg::MON_W-1:0] mon_meta_reg;
	logic [gfs_pkg::MON_W-1:0] mon_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mon_meta_reg <= '0;
			mon_reg <= '0;
		end else if (ce_i) begin
			mon_meta_reg <= monitor_i; // R16 R21
			mon_reg <= mon_meta_reg; // R21
		end
	end

	// ****************************************************************
	// wishbone access
	// ****************************************************************
	logic bus_req;
	logic [5:0] idx;
	logic wr;
	logic rd_warn;
	logic rd_oc;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx = wb_adr_i[7:2];
	assign wr = bus_req & wb_we_i;
	assign rd_warn = bus_req & ~wb_we_i & hit(idx, gfs_pkg::IDX_WARN);
	assign rd_oc = bus_req & ~wb_we_i & hit(idx, gfs_pkg::IDX_OC);

	// ****************************************************************
	// configuration
	// ****************************************************************
	logic [1:0] set_a_reg;
	logic [1:0] set_b_reg;
	logic chk_dis_reg;
	logic lock_dis_reg;
	logic clr_reg;
	logic [2:0] oc_mode_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_a_reg <= gfs_pkg::TMR_RST;
			set_b_reg <= gfs_pkg::TMR_RST;
			chk_dis_reg <= 1'b0;
			lock_dis_reg <= 1'b0;
			clr_reg <= 1'b0;
			oc_mode_reg <= gfs_pkg::OC_MODE_RST;
		end else if (ce_i) begin
			// clear request lasts one cycle, then reads back as zero
			clr_reg <= 1'b0; // R17
			if (wr && hit(idx, gfs_pkg::IDX_TMR_A) && wb_sel_i[1])
				set_a_reg <= wb_dat_i[gfs_pkg::TMR_LSB +: 2]; // R03
			if (wr && hit(idx, gfs_pkg::IDX_TMR_B) && wb_sel_i[1])
				set_b_reg <= wb_dat_i[gfs_pkg::TMR_LSB +: 2]; // R03
			if (wr && hit(idx, gfs_pkg::IDX_CTRL)) begin
				if (wb_sel_i[1]) begin
					chk_dis_reg <= wb_dat_i[gfs_pkg::CTRL_CHK_DIS]; // R04
					lock_dis_reg <= wb_dat_i[gfs_pkg::CTRL_LOCK_DIS]; // R11
				end
				if (wb_sel_i[0])
					clr_reg <= wb_dat_i[gfs_pkg::CTRL_CLR]; // R17
			end
			if (wr && hit(idx, gfs_pkg::IDX_OC_MODE) && wb_sel_i[0])
				oc_mode_reg <= wb_dat_i[2:0]; // R07
		end
	end

	// ****************************************************************
	// gate timer check
	// ****************************************************************
	gfs_gate_if gif ();

	assign gif.cmd = gate_cmd_i;
	assign gif.fb = gate_fb_i;
	assign gif.setting_a = set_a_reg;
	assign gif.setting_b = set_b_reg;
	assign gif.check_disable = chk_dis_reg;

	gfs_gate_timer #(
		.UNIT_CYC(GATE_UNIT_CYC)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.gif(gif)
	);

	// ****************************************************************
	// latched faults
	// ****************************************************************
	logic [gfs_pkg::F3_W-1:0] cond3;
	logic [gfs_pkg::F3_W-1:0] flt3_reg;
	logic [5:0] mis_reg;
	logic [2:0] src_oc_reg;
	logic [5:0] ds_lat_reg;
	logic [5:0] ds_cond;
	logic en_prev_reg;
	logic clr_evt;

	always_comb begin
		cond3 = '0;
		cond3[gfs_pkg::F3_ABS_OV] = mon_reg[gfs_pkg::MON_PUMP_ABS_OV]; // R12
		cond3[gfs_pkg::F3_REL_OV] = mon_reg[gfs_pkg::MON_PUMP_REL_OV]; // R12
		cond3[gfs_pkg::F3_PUMP_UV] = mon_reg[gfs_pkg::MON_PUMP_UV]; // R13 R15
		cond3[gfs_pkg::F3_REF_UV] = mon_reg[gfs_pkg::MON_REF_UV];
		cond3[gfs_pkg::F3_LS_UV] = mon_reg[gfs_pkg::MON_LS_REG_UV]; // R14 R15
		cond3[gfs_pkg::F3_ANALOG_UV] = mon_reg[gfs_pkg::MON_ANALOG_UV]; // R06
		cond3[gfs_pkg::F3_OT_SD] = mon_reg[gfs_pkg::MON_OT_SD]; // R06
		cond3[gfs_pkg::F3_LOCK] = mon_reg[gfs_pkg::MON_DRV_LOCK]; // R10 R11
	end

	assign ds_cond = mon_reg[gfs_pkg::MON_DS_OC +: 6];
	// enable pulse counts on its falling edge; the new rise finds faults gone
	assign clr_evt = clr_reg | (en_prev_reg & ~gate_enable_i); // R17

	// a standing condition keeps its bit, so a clear never loses an event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt3_reg <= '0;
			mis_reg <= '0;
			src_oc_reg <= '0;
			ds_lat_reg <= '0;
			en_prev_reg <= 1'b0;
		end else if (ce_i) begin
			en_prev_reg <= gate_enable_i;
			flt3_reg <= cond3 | (flt3_reg & ~{gfs_pkg::F3_W{clr_evt}}); // R06 R17
			mis_reg <= gif.mismatch | (mis_reg & ~{6{clr_evt}}); // R02 R06
			src_oc_reg <= mon_reg[gfs_pkg::MON_SRC_OC +: 3] | (src_oc_reg & ~{3{clr_evt}}); // R05
			ds_lat_reg <= (ds_cond & {6{oc_mode_reg == gfs_pkg::OC_LATCHED}})
				| (ds_lat_reg & ~{6{clr_evt}}); // R07
		end
	end

	logic [gfs_pkg::F3_W-1:0] flt3_act;
	logic supply_off;
	logic pull_low;
	logic fault_any;

	always_comb begin
		flt3_act = flt3_reg;
		flt3_act[gfs_pkg::F3_LOCK] = flt3_reg[gfs_pkg::F3_LOCK] & ~lock_dis_reg; // R11
	end

	assign supply_off = (|flt3_act) | (|mis_reg); // R06
	assign pull_low = supply_off | (|src_oc_reg) | (|ds_lat_reg); // R05 R07
	assign fault_any = (|flt3_reg) | (|mis_reg) | (|src_oc_reg) | (|ds_lat_reg); // R19

	// ****************************************************************
	// warnings
	// ****************************************************************
	logic [3:0] w1_cond;
	logic [3:0] w1_prev_reg;
	logic [3:0] w1_pend_reg;
	logic [5:0] w2_cond;
	logic [5:0] w2_prev_reg;
	logic [5:0] w2_pend_reg;
	logic warn_active;

	assign w1_cond = {mon_reg[gfs_pkg::MON_PUMP_UV_WARN], mon_reg[gfs_pkg::MON_OT_WARN],
		mon_reg[gfs_pkg::MON_MAIN_HIGH], mon_reg[gfs_pkg::MON_MAIN_LOW]}; // R08 R09
	assign w2_cond = ds_cond & {6{oc_mode_reg == gfs_pkg::OC_REPORT}}; // R07

	// a fresh rise beats a read in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w1_prev_reg <= '0;
			w1_pend_reg <= '0;
			w2_prev_reg <= '0;
			w2_pend_reg <= '0;
		end else if (ce_i) begin
			w1_prev_reg <= w1_cond;
			w2_prev_reg <= w2_cond;
			w1_pend_reg <= (w1_cond & ~w1_prev_reg) | (w1_pend_reg & ~{4{rd_warn}}); // R18
			w2_pend_reg <= (w2_cond & ~w2_prev_reg) | (w2_pend_reg & ~{6{rd_oc}}); // R18
		end
	end

	assign warn_active = (|w1_pend_reg) | (|w2_pend_reg);

	// ****************************************************************
	// fault pin cadence
	// ****************************************************************
	logic [TOG_W-1:0] tog_cnt_reg;
	logic tog_low_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tog_cnt_reg <= '0;
			tog_low_reg <= 1'b1;
		end else if (ce_i) begin
			if (!warn_active) begin
				tog_cnt_reg <= '0;
				tog_low_reg <= 1'b1;
			end else if (tog_cnt_reg == TOG_W'(WARN_HALF_CYC - 1)) begin
				tog_cnt_reg <= '0;
				tog_low_reg <= ~tog_low_reg; // R18
			end else begin
				tog_cnt_reg <= tog_cnt_reg + TOG_W'(1);
			end
		end
	end

	// ****************************************************************
	// operating state
	// ****************************************************************
	gfs_pkg::gfs_state_t state_reg;
	gfs_pkg::gfs_state_t state_next;

	always_comb begin
		case (state_reg)
			gfs_pkg::ST_STANDBY: state_next = (gate_enable_i && !pull_low)
				? gfs_pkg::ST_OPERATE : gfs_pkg::ST_STANDBY;
			gfs_pkg::ST_OPERATE: state_next = (!gate_enable_i || pull_low)
				? gfs_pkg::ST_STANDBY : gfs_pkg::ST_OPERATE;
			default: state_next = gfs_pkg::ST_STANDBY;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_reg <= gfs_pkg::ST_STANDBY;
		else if (ce_i)
			state_reg <= state_next;
	end

	// ****************************************************************
	// pin outputs
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_out_o <= '0;
			strong_pd_o <= '0;
			gate_supply_en_o <= 1'b0;
			fault_out_n_o <= 1'b0;
			fault_out_n_oe_o <= 1'b0;
		end else if (ce_i) begin
			gate_out_o <= (state_next == gfs_pkg::ST_OPERATE) ? gate_cmd_i : '0; // R05 R06
			strong_pd_o <= gif.strong_pd; // R01
			gate_supply_en_o <= gate_enable_i & ~supply_off; // R06 R15
			fault_out_n_o <= 1'b0;
			// temperature flags never reach the pin
			fault_out_n_oe_o <= fault_any | (warn_active & tog_low_reg); // R19 R20 R21
		end
	end

	// ****************************************************************
	// read data and acknowledge
	// ****************************************************************
	logic [31:0] rd_val;

	always_comb begin
		rd_val = '0;
		case (idx)
			gfs_pkg::IDX_WARN: begin
				rd_val[gfs_pkg::W1_MAIN_LOW] = w1_cond[0] | w1_pend_reg[0]; // R08
				rd_val[gfs_pkg::W1_MAIN_HIGH] = w1_cond[1] | w1_pend_reg[1]; // R09
				rd_val[gfs_pkg::W1_OT_WARN] = w1_cond[2] | w1_pend_reg[2];
				rd_val[gfs_pkg::W1_PUMP_WARN] = w1_cond[3] | w1_pend_reg[3];
				rd_val[gfs_pkg::W1_TEMP1] = mon_reg[gfs_pkg::MON_TEMP_LVL]; // R20
				rd_val[gfs_pkg::W1_TEMP2] = mon_reg[gfs_pkg::MON_TEMP_LVL + 1];
				rd_val[gfs_pkg::W1_TEMP3] = mon_reg[gfs_pkg::MON_TEMP_LVL + 2];
				rd_val[gfs_pkg::W1_TEMP4] = mon_reg[gfs_pkg::MON_TEMP_LVL + 3];
				rd_val[gfs_pkg::W1_FAULT] = fault_any; // R19
			end
			gfs_pkg::IDX_OC: begin
				rd_val[gfs_pkg::OC_SRC_LSB +: 3] = src_oc_reg; // R05
				rd_val[gfs_pkg::OC_DS_LSB +: 6] = ds_lat_reg | w2_cond | w2_pend_reg; // R07
			end
			gfs_pkg::IDX_FLT: begin
				rd_val[gfs_pkg::F3_W-1:0] = flt3_reg; // R10 R11 R12 R13 R14
				rd_val[gfs_pkg::F3_GDF] = |mis_reg;
			end
			gfs_pkg::IDX_MISM: rd_val[5:0] = mis_reg; // R02
			gfs_pkg::IDX_TMR_A: rd_val[gfs_pkg::TMR_LSB +: 2] = set_a_reg;
			gfs_pkg::IDX_TMR_B: rd_val[gfs_pkg::TMR_LSB +: 2] = set_b_reg;
			gfs_pkg::IDX_CTRL: begin
				rd_val[gfs_pkg::CTRL_CLR] = clr_reg;
				rd_val[gfs_pkg::CTRL_CHK_DIS] = chk_dis_reg;
				rd_val[gfs_pkg::CTRL_LOCK_DIS] = lock_dis_reg;
			end
			gfs_pkg::IDX_OC_MODE: rd_val[2:0] = oc_mode_reg;
			default: rd_val = '0;
		endcase
	end

	// every address answers; unmapped ones read zero and drop writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i)
				wb_dat_o <= rd_val;
		end
	end
endmodule : gfs_fault_supervisor
`default_nettype wire

//--- hw/gfs_pkg.sv
package gfs_pkg;
	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int WARN_HALF_NS = 56000;
	localparam int WARN_HALF_CYC = (WARN_HALF_NS * 1000) / CLK_PERIOD_PS;
	localparam int GATE_UNIT_NS = 1000;
	localparam int GATE_UNIT_CYC = (GATE_UNIT_NS * 1000) / CLK_PERIOD_PS;

	// ****************************************************************
	// gate outputs
	// ****************************************************************
	localparam int FET_N = 6;
	localparam int PHASE_N = 3;

	// ****************************************************************
	// monitor input positions
	// ****************************************************************
	localparam int MON_MAIN_LOW = 0;
	localparam int MON_MAIN_HIGH = 1;
	localparam int MON_DRV_LOCK = 2;
	localparam int MON_ANALOG_UV = 3;
	localparam int MON_REF_UV = 4;
	localparam int MON_PUMP_UV_WARN = 5;
	localparam int MON_PUMP_UV = 6;
	localparam int MON_LS_REG_UV = 7;
	localparam int MON_PUMP_REL_OV = 8;
	localparam int MON_PUMP_ABS_OV = 9;
	localparam int MON_OT_WARN = 10;
	localparam int MON_OT_SD = 11;
	localparam int MON_TEMP_LVL = 12;
	localparam int MON_SRC_OC = 16;
	localparam int MON_DS_OC = 19;
	localparam int MON_W = 25;

	// ****************************************************************
	// register indices, byte address is four times the index
	// ****************************************************************
	localparam logic [5:0] IDX_WARN = 6'h01;
	localparam logic [5:0] IDX_OC = 6'h02;
	localparam logic [5:0] IDX_FLT = 6'h03;
	localparam logic [5:0] IDX_MISM = 6'h04;
	localparam logic [5:0] IDX_TMR_A = 6'h05;
	localparam logic [5:0] IDX_TMR_B = 6'h06;
	localparam logic [5:0] IDX_CTRL = 6'h09;
	localparam logic [5:0] IDX_OC_MODE = 6'h0c;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int W1_OT_WARN = 0;
	localparam int W1_TEMP1 = 3;
	localparam int W1_TEMP2 = 2;
	localparam int W1_TEMP3 = 1;
	localparam int W1_TEMP4 = 8;
	localparam int W1_PUMP_WARN = 4;
	localparam int W1_MAIN_HIGH = 6;
	localparam int W1_MAIN_LOW = 7;
	localparam int W1_FAULT = 10;
	localparam int OC_SRC_LSB = 0;
	localparam int OC_DS_LSB = 3;
	localparam int F3_ABS_OV = 0;
	localparam int F3_REL_OV = 1;
	localparam int F3_PUMP_UV = 2;
	localparam int F3_REF_UV = 3;
	localparam int F3_LS_UV = 4;
	localparam int F3_ANALOG_UV = 5;
	localparam int F3_GDF = 7;
	localparam int F3_OT_SD = 8;
	localparam int F3_LOCK = 10;
	localparam int F3_W = 11;
	localparam int TMR_LSB = 8;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_CHK_DIS = 8;
	localparam int CTRL_LOCK_DIS = 9;

	// ****************************************************************
	// reset values and modes
	// ****************************************************************
	localparam logic [1:0] TMR_RST = 2'h0;
	localparam logic [2:0] OC_LATCHED = 3'h0;
	localparam logic [2:0] OC_REPORT = 3'h1;
	localparam logic [2:0] OC_DISABLED = 3'h2;
	localparam logic [2:0] OC_MODE_RST = 3'h0;

	typedef enum logic [0:0] {ST_STANDBY, ST_OPERATE} gfs_state_t;
endpackage : gfs_pkg

//--- hw/gfs_gate_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gfs_gate_if;
	logic [5:0] cmd;
	logic [5:0] fb;
	logic [1:0] setting_a;
	logic [1:0] setting_b;
	logic check_disable;
	logic [5:0] strong_pd;
	logic [5:0] mismatch;

	modport ctrl (
		output cmd, fb, setting_a, setting_b, check_disable,
		input strong_pd, mismatch
	);
	modport chk (
		input cmd, fb, setting_a, setting_b, check_disable,
		output strong_pd, mismatch
	);
endinterface : gfs_gate_if
`default_nettype wire

//--- hw/gfs_gate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gfs_gate_timer #(
	parameter int UNIT_CYC = gfs_pkg::GATE_UNIT_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// gate signals
	gfs_gate_if.chk gif
);
	localparam int CNT_W = $clog2(4 * UNIT_CYC + 1);

	logic [5:0] pd_w;
	logic [5:0] mis_w;

	// ****************************************************************
	// per gate timer
	// ****************************************************************
	for (genvar i = 0; i < gfs_pkg::FET_N; i++) begin : g_fet
		localparam int OPP = i ^ 1;
		logic prev_q;
		logic run_q;
		logic rise_q;
		logic mis_q;
		logic [CNT_W-1:0] cnt_q;
		logic [1:0] sel;
		logic [CNT_W-1:0] load;

		// rising command uses the second polarity setting
		assign sel = gif.cmd[i] ? gif.setting_b : gif.setting_a; // R03
		assign load = CNT_W'(UNIT_CYC * (int'(sel) + 1));

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				prev_q <= 1'b0;
				run_q <= 1'b0;
				rise_q <= 1'b0;
				mis_q <= 1'b0;
				cnt_q <= '0;
			end else if (ce_i) begin
				prev_q <= gif.cmd[i];
				mis_q <= 1'b0;
				if (gif.cmd[i] != prev_q) begin
					run_q <= 1'b1;
					rise_q <= gif.cmd[i];
					cnt_q <= load;
				end else if (run_q) begin
					if (cnt_q == CNT_W'(1)) begin
						run_q <= 1'b0;
						mis_q <= ~gif.check_disable & (gif.fb[i] != gif.cmd[i]); // R02 R04
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
			end
		end

		// opposite gate held hard off while this one turns on
		assign pd_w[OPP] = run_q & rise_q; // R01
		assign mis_w[i] = mis_q;
	end

	assign gif.strong_pd = pd_w;
	assign gif.mismatch = mis_w;
endmodule : gfs_gate_timer
`default_nettype wire

//--- dv/gfs_fault_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gfs_fault_supervisor_properties #(
	parameter int WARN_HALF_CYC = 8,
	parameter int GATE_UNIT_CYC = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// gates and monitors
	input wire logic gate_enable_i,
	input wire logic [5:0] gate_cmd_i,
	input wire logic [5:0] gate_out_o,
	input wire logic [5:0] strong_pd_o,
	input wire logic gate_supply_en_o,
	input wire logic [gfs_pkg::MON_W-1:0] monitor_i,
	input wire logic fault_out_n_oe_o
);
	// ****************************************************************
	// monitors need two sync flops, a latch and an output flop
	// ****************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a one cycle answer");
	src_oc_a: assert property (monitor_i[16] [*4] |=> gate_out_o == 6'h00 && fault_out_n_oe_o)
		else $error("source overcurrent did not shut gates");
	analog_uv_a: assert property (monitor_i[3] [*4] |=> !gate_supply_en_o && fault_out_n_oe_o)
		else $error("analog undervoltage left supplies on");
	pump_uv_a: assert property (monitor_i[6] [*4] |=> !gate_supply_en_o && fault_out_n_oe_o)
		else $error("pump undervoltage left supplies on");
	ls_uv_a: assert property (monitor_i[7] [*4] |=> !gate_supply_en_o && gate_out_o == 6'h00)
		else $error("lowside undervoltage left driver on");
	pump_ov_a: assert property ((monitor_i[8] || monitor_i[9]) [*4] |=> fault_out_n_oe_o)
		else $error("pump overvoltage did not hold pin");
	lockout_pin_a: assert property (monitor_i[2] [*4] |=> fault_out_n_oe_o)
		else $error("driver lockout did not hold pin");
	gate_follow_a: assert property ((gate_enable_i && !fault_out_n_oe_o
		&& $stable(gate_cmd_i)) [*3] |-> gate_out_o == gate_cmd_i)
		else $error("gates do not follow command without fault");
	strong_pd_a: assert property ($rose(gate_cmd_i[0]) |-> ##2 strong_pd_o[1] ##[1:30] !strong_pd_o[1])
		else $error("opposite gate strong pulldown wrong");
	fault_pin_a: assert property ($fell(gate_supply_en_o) && gate_enable_i |-> ##[0:2] fault_out_n_oe_o)
		else $error("supply shutdown without fault pin");
endmodule : gfs_fault_supervisor_properties

bind gfs_fault_supervisor gfs_fault_supervisor_properties #(
	.WARN_HALF_CYC(WARN_HALF_CYC),
	.GATE_UNIT_CYC(GATE_UNIT_CYC)
) u_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.gate_enable_i(gate_enable_i),
	.gate_cmd_i(gate_cmd_i),
	.gate_out_o(gate_out_o),
	.strong_pd_o(strong_pd_o),
	.gate_supply_en_o(gate_supply_en_o),
	.monitor_i(monitor_i),
	.fault_out_n_oe_o(fault_out_n_oe_o)
);
`default_nettype wire

//--- dv/gfs_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module gfs_bridge_model (
	// gate side
	input wire logic [5:0] gate_out_i,
	input wire logic [5:0] short_gnd_i,
	output logic [5:0] gate_fb_o,
	// open-drain fault line
	input wire logic pin_drv_i,
	input wire logic pin_oe_i,
	output logic pin_o
);
	// a gate shorted to ground never rises, whatever is commanded
	assign gate_fb_o = gate_out_i & ~short_gnd_i;
	// external pull-up holds the line high when nobody pulls it
	assign pin_o = pin_oe_i ? pin_drv_i : 1'b1;
endmodule : gfs_bridge_model
`default_nettype wire

//--- dv/gfs_fault_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gfs_fault_supervisor_tb;
	localparam int HALF = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic gate_enable_i = 1'b1;
	logic [5:0] gate_cmd_i = 6'h24;
	logic [5:0] gate_fb;
	logic [5:0] gate_out_o;
	logic [5:0] strong_pd_o;
	logic [5:0] short_mask = 6'h00;
	logic [24:0] monitor_i = 25'h0;
	logic gate_supply_en_o;
	logic pin;
	logic pin_drv;
	logic fault_out_n_oe_o;
	logic [31:0] rd_data;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	int fm[7] = '{gfs_pkg::MON_DRV_LOCK, gfs_pkg::MON_ANALOG_UV, gfs_pkg::MON_PUMP_UV,
		gfs_pkg::MON_LS_REG_UV, gfs_pkg::MON_PUMP_REL_OV, gfs_pkg::MON_PUMP_ABS_OV, gfs_pkg::MON_OT_SD};
	int fbit[7] = '{10, 5, 2, 4, 1, 0, 8};
	logic [2:0] md[3] = '{gfs_pkg::OC_LATCHED, gfs_pkg::OC_REPORT, gfs_pkg::OC_DISABLED};

	// ****************************************************************
	// clock, design and far side
	// ****************************************************************
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	gfs_fault_supervisor #(.WARN_HALF_CYC(HALF), .GATE_UNIT_CYC(4)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .gate_enable_i(gate_enable_i), .gate_cmd_i(gate_cmd_i),
		.gate_fb_i(gate_fb), .gate_out_o(gate_out_o), .strong_pd_o(strong_pd_o),
		.gate_supply_en_o(gate_supply_en_o), .monitor_i(monitor_i), .fault_out_n_i(pin),
		.fault_out_n_o(pin_drv), .fault_out_n_oe_o(fault_out_n_oe_o));
	gfs_bridge_model u_bridge (.gate_out_i(gate_out_o), .short_gnd_i(short_mask),
		.gate_fb_o(gate_fb), .pin_drv_i(pin_drv), .pin_oe_i(fault_out_n_oe_o), .pin_o(pin));

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk32
	task automatic chk1(input string nm, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1
	task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd_data = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 32'h0);
		chk32("register", exp, rd_data);
	endtask : rdchk
	task automatic mon(input int b, input logic v);
		@(posedge clk_i);
		monitor_i[b] <= v;
		repeat (6) @(posedge clk_i);
	endtask : mon
	// pin pattern repeats every 2*HALF, so a 4*HALF window counts exactly 2*HALF
	task automatic oe_count(input int exp);
		n = 0;
		repeat (4 * HALF) begin
			@(posedge clk_i);
			n += int'(!pin);
		end
		chk32("pin low cycles", exp, n);
	endtask : oe_count
	task automatic clr();
		wb(1'b1, gfs_pkg::IDX_CTRL, 32'h1 << gfs_pkg::CTRL_CLR);
		repeat (3) @(posedge clk_i);
	endtask : clr

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdchk(gfs_pkg::IDX_TMR_A, 32'h0);
		rdchk(gfs_pkg::IDX_OC_MODE, 32'h0);
		wb(1'b1, gfs_pkg::IDX_TMR_A, 32'h300);
		rdchk(gfs_pkg::IDX_TMR_A, 32'h300);
		wb(1'b1, 6'h3f, 32'hffff_ffff);
		rdchk(6'h3f, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 2; i++) begin
			mon(i, 1'b1);
			oe_count(2 * HALF);
			chk32("gates", gate_cmd_i, gate_out_o);
			rdchk(gfs_pkg::IDX_WARN, 32'h80 >> i);
			oe_count(0);
			rdchk(gfs_pkg::IDX_WARN, 32'h80 >> i);
			mon(i, 1'b0);
			rdchk(gfs_pkg::IDX_WARN, 32'h0);
		end
		mon(gfs_pkg::MON_TEMP_LVL, 1'b1);
		rdchk(gfs_pkg::IDX_WARN, 32'h8);
		oe_count(0);
		mon(gfs_pkg::MON_TEMP_LVL, 1'b0);
		ce_i <= 1'b0;
		mon(gfs_pkg::MON_MAIN_LOW, 1'b1);
		mon(gfs_pkg::MON_MAIN_LOW, 1'b0);
		ce_i <= 1'b1;
		oe_count(0);
		$display("test warnings done");
		mon(gfs_pkg::MON_MAIN_LOW, 1'b1);
		mon(gfs_pkg::MON_SRC_OC, 1'b1);
		oe_count(4 * HALF);
		chk32("gates", 32'h0, gate_out_o);
		rdchk(gfs_pkg::IDX_OC, 32'h1);
		rdchk(gfs_pkg::IDX_WARN, 32'h480);
		mon(gfs_pkg::MON_SRC_OC, 1'b0);
		mon(gfs_pkg::MON_MAIN_LOW, 1'b0);
		oe_count(4 * HALF);
		clr();
		oe_count(0);
		rdchk(gfs_pkg::IDX_OC, 32'h0);
		$display("test precedence done");
		for (int i = 0; i < 7; i++) begin
			if (i == 2) wb(1'b1, gfs_pkg::IDX_CTRL, 32'h300);
			mon(fm[i], 1'b1);
			chk1("supply", 1'b0, gate_supply_en_o);
			chk32("gates", 32'h0, gate_out_o);
			rdchk(gfs_pkg::IDX_FLT, 32'h1 << fbit[i]);
			rdchk(gfs_pkg::IDX_WARN, 32'h400);
			clr();
			chk1("held", 1'b1, fault_out_n_oe_o);
			mon(fm[i], 1'b0);
			if (i % 2 == 1) begin
				clr();
			end else begin
				@(posedge clk_i);
				gate_enable_i <= 1'b0;
				@(posedge clk_i);
				gate_enable_i <= 1'b1;
				repeat (3) @(posedge clk_i);
			end
			chk1("released", 1'b0, fault_out_n_oe_o);
		end
		wb(1'b1, gfs_pkg::IDX_CTRL, 32'h200);
		mon(gfs_pkg::MON_DRV_LOCK, 1'b1);
		chk32("gates", gate_cmd_i, gate_out_o);
		rdchk(gfs_pkg::IDX_FLT, 32'h400);
		mon(gfs_pkg::MON_DRV_LOCK, 1'b0);
		clr();
		$display("test latched faults done");
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, gfs_pkg::IDX_CTRL, i == 0 ? 32'h0 : 32'h100);
			@(posedge clk_i);
			short_mask <= 6'h01;
			gate_cmd_i[0] <= 1'b1;
			repeat (30) @(posedge clk_i);
			rdchk(gfs_pkg::IDX_MISM, i == 0 ? 32'h1 : 32'h0);
			rdchk(gfs_pkg::IDX_FLT, i == 0 ? 32'h80 : 32'h0);
			chk1("supply", i == 1, gate_supply_en_o);
			@(posedge clk_i);
			short_mask <= 6'h00;
			gate_cmd_i[0] <= 1'b0;
			repeat (30) @(posedge clk_i);
			clr();
		end
		$display("test gate check done");
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, gfs_pkg::IDX_OC_MODE, {29'h0, md[i]});
			mon(gfs_pkg::MON_DS_OC, 1'b1);
			oe_count(i == 0 ? 4 * HALF : (i == 1 ? 2 * HALF : 0));
			chk32("gates", i == 0 ? 32'h0 : {26'h0, gate_cmd_i}, gate_out_o);
			rdchk(gfs_pkg::IDX_OC, i == 2 ? 32'h0 : 32'h8);
			mon(gfs_pkg::MON_DS_OC, 1'b0);
			clr();
		end
		wb(1'b1, gfs_pkg::IDX_OC_MODE, 32'h0);
		$display("test overcurrent modes done");
		summarize();
	end
endmodule : gfs_fault_supervisor_tb
`default_nettype wire
